// [adcd_diag.sv]
`timescale 1ns/100ps
module adcd_diag
	import adcd_pkg::*;
(
	input  wire logic                         core_clk_i,
	input  wire logic                         rstn_i,
	input  wire logic [11:0]                  paddr_i,
	input  wire logic                         psel_i,
	input  wire logic                         penable_i,
	input  wire logic                         pwrite_i,
	input  wire logic [31:0]                  pwdata_i,
	output logic      [31:0]                  prdata_o,
	output logic                              pready_o,
	output logic                              pslverr_o,
	input  wire logic [NUM_CH-1:0][15:0]      conv_raw_i,
	input  wire logic [NUM_CH-1:0]            conv_valid_i,
	input  wire logic [NUM_CH-1:0]            open_hi_i,
	input  wire logic [NUM_CH-1:0]            open_lo_i,
	output logic      [NUM_CH-1:0]            src_pos_en_o,
	output logic      [NUM_CH-1:0]            src_neg_en_o,
	output logic      [NUM_CH-1:0]            test_ref_sel_o,
	output logic      [NUM_CH-1:0][13:0]      test_div_o,
	output logic      [NUM_CH-1:0]            bipolar_o,
	output logic                              irq_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	// APB slave, one wait state so read data comes from a flop
	logic              pready_reg, pready_next;
	logic              pslverr_reg, pslverr_next;
	logic [31:0]       prdata_reg, prdata_next;
	logic              acc_wr;
	logic              addr_ok;
	adcd_ctrl_s [NUM_CH-1:0] ctrl_reg, ctrl_next;
	logic [NUM_CH-1:0][15:0] res_reg, res_next;
	logic [ST_W-1:0]   status_reg, status_next;
	logic [ST_W-1:0]   mask_reg, mask_next;
	logic              irq_reg, irq_next;
	logic [ST_W-1:0]   evt_vec;
	logic [ST_W-1:0]   w1c;

	assign acc_wr = psel_i & penable_i & pready_reg & pwrite_i;

	always_comb begin
		addr_ok = 1'b1;
		prdata_next = 32'h0000_0000;
		if (paddr_i == ADDR_CURR_CTRL) begin
			prdata_next[SRC_POS_BIT] = ctrl_reg[CH_CURR].pos_src;
			prdata_next[SRC_NEG_BIT] = ctrl_reg[CH_CURR].neg_src;
			prdata_next[TSEL_HI:TSEL_LO] = ctrl_reg[CH_CURR].test_sel;
			prdata_next[BIPOLAR_BIT] = ctrl_reg[CH_CURR].bipolar;
			prdata_next[GAIN_HI:GAIN_LO] = ctrl_reg[CH_CURR].gain;
		end else if (paddr_i == ADDR_TEMP_CTRL) begin
			prdata_next[SRC_POS_BIT] = ctrl_reg[CH_TEMP].pos_src;
			prdata_next[SRC_NEG_BIT] = ctrl_reg[CH_TEMP].neg_src;
			prdata_next[TSEL_HI:TSEL_LO] = ctrl_reg[CH_TEMP].test_sel;
			prdata_next[BIPOLAR_BIT] = ctrl_reg[CH_TEMP].bipolar;
			prdata_next[GAIN_HI:GAIN_LO] = ctrl_reg[CH_TEMP].gain;
		end else if (paddr_i == ADDR_CURR_RES) begin
			prdata_next[15:0] = res_reg[CH_CURR];
		end else if (paddr_i == ADDR_TEMP_RES) begin
			prdata_next[15:0] = res_reg[CH_TEMP];
		end else if (paddr_i == ADDR_STATUS) begin
			prdata_next[ST_W-1:0] = status_reg;
		end else if (paddr_i == ADDR_MASK) begin
			prdata_next[ST_W-1:0] = mask_reg;
		end else begin
			addr_ok = 1'b0;
		end
		pready_next = psel_i & penable_i & ~pready_reg;
		pslverr_next = psel_i & penable_i & ~pready_reg & ~addr_ok;
		if (!(psel_i & penable_i & ~pready_reg)) begin
			prdata_next = prdata_reg;
		end
	end

	// Control and mask writes; status bits set by events win over a same-cycle clear
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		w1c = '0;
		if (acc_wr && paddr_i == ADDR_CURR_CTRL) begin
			ctrl_next[CH_CURR].pos_src = pwdata_i[SRC_POS_BIT];
			ctrl_next[CH_CURR].neg_src = pwdata_i[SRC_NEG_BIT];
			ctrl_next[CH_CURR].test_sel = pwdata_i[TSEL_HI:TSEL_LO];
			ctrl_next[CH_CURR].bipolar = pwdata_i[BIPOLAR_BIT];
			ctrl_next[CH_CURR].gain = pwdata_i[GAIN_HI:GAIN_LO];
		end else if (acc_wr && paddr_i == ADDR_TEMP_CTRL) begin
			ctrl_next[CH_TEMP].pos_src = pwdata_i[SRC_POS_BIT];
			ctrl_next[CH_TEMP].neg_src = pwdata_i[SRC_NEG_BIT];
			ctrl_next[CH_TEMP].test_sel = pwdata_i[TSEL_HI:TSEL_LO];
			ctrl_next[CH_TEMP].bipolar = pwdata_i[BIPOLAR_BIT];
			ctrl_next[CH_TEMP].gain = pwdata_i[GAIN_HI:GAIN_LO];
		end else if (acc_wr && paddr_i == ADDR_STATUS) begin
			w1c = pwdata_i[ST_W-1:0];
		end else if (acc_wr && paddr_i == ADDR_MASK) begin
			mask_next = pwdata_i[ST_W-1:0];
		end
		status_next = (status_reg & ~w1c) | evt_vec;
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			ctrl_reg    <= {NUM_CH{CTRL_RST}};
			status_reg  <= ST_RST;
			mask_reg    <= MASK_RST;
			irq_reg     <= 1'b0;
		end else begin
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
			ctrl_reg    <= ctrl_next;
			status_reg  <= status_next;
			mask_reg    <= mask_next;
			irq_reg     <= irq_next;
		end
	end

	assign pready_o  = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign prdata_o  = prdata_reg;
	assign irq_o     = irq_reg;

	// Open-circuit comparators are analog; three flops, a change counts once stages two and three agree
	logic [2*NUM_CH-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;

	always_comb begin
		filt_next = filt_reg;
		for (int i = 0; i < 2*NUM_CH; i++) begin
			if (sync2_reg[i] == sync3_reg[i]) begin
				filt_next[i] = sync3_reg[i];
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
			filt_reg  <= '0;
		end else begin
			sync1_reg <= {open_lo_i, open_hi_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg  <= filt_next;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			adcd_state_e  state_reg, state_next;
			logic [15:0]  base_reg, base_next;
			logic [15:0]  forced;
			logic [1:0]   src_prev_reg;
			logic [13:0]  div_reg, div_next;
			logic [3:0]   gain_c;
			logic         ref_reg, ref_next;
			logic         ev_short, ev_open;
			logic         src_on, src_rise;

			assign src_on   = ctrl_reg[ch].pos_src | ctrl_reg[ch].neg_src;
			assign src_rise = |({ctrl_reg[ch].pos_src, ctrl_reg[ch].neg_src} & ~src_prev_reg);

			// A floating input rails the converter only when its own source is pushing current
			always_comb begin
				forced = conv_raw_i[ch];
				if (ctrl_reg[ch].bipolar && ctrl_reg[ch].pos_src && filt_reg[ch]) begin
					forced = POS_FS;
				end else if (ctrl_reg[ch].bipolar && ctrl_reg[ch].neg_src && filt_reg[NUM_CH+ch]) begin
					forced = NEG_FS;
				end
				res_next[ch] = conv_valid_i[ch] ? forced : res_reg[ch];
			end

			// Gain codes above the top range are treated as the top range
			always_comb begin
				gain_c = (ctrl_reg[ch].gain > GAIN_CODE_MAX) ? GAIN_CODE_MAX : ctrl_reg[ch].gain;
				ref_next = (ctrl_reg[ch].test_sel == TSEL_REF) ? 1'b1 : 1'b0;
				if (ch == CH_TEMP || gain_c <= GAIN_FIXED_MAX) begin
					div_next = DIV_FIXED;
				end else begin
					div_next = DIV_GAIN_MUL << gain_c;
				end
			end

			// The first result after switching is discarded since the source may not have settled
			always_comb begin
				state_next = state_reg;
				base_next  = base_reg;
				ev_short   = 1'b0;
				ev_open    = 1'b0;
				case (state_reg)
					ADCD_IDLE: begin
						if (!src_on && conv_valid_i[ch]) begin
							base_next = forced;
						end
						if (src_rise) begin
							state_next = ADCD_SETTLE;
						end
					end
					ADCD_SETTLE: begin
						if (!src_on) begin
							state_next = ADCD_IDLE;
						end else if (conv_valid_i[ch]) begin
							state_next = ADCD_CHECK;
						end
					end
					ADCD_CHECK: begin
						if (!src_on) begin
							state_next = ADCD_IDLE;
						end else if (conv_valid_i[ch]) begin
							state_next = ADCD_IDLE;
							ev_open  = ctrl_reg[ch].bipolar && (forced == POS_FS || forced == NEG_FS);
							ev_short = !ev_open && forced == base_reg;
						end
					end
					default: begin
						state_next = ADCD_IDLE;
					end
				endcase
			end

			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					state_reg    <= ADCD_IDLE;
					base_reg     <= RES_RST;
					res_reg[ch]  <= RES_RST;
					src_prev_reg <= 2'h0;
					div_reg      <= DIV_FIXED;
					ref_reg      <= 1'b0;
				end else begin
					state_reg    <= state_next;
					base_reg     <= base_next;
					res_reg[ch]  <= res_next[ch];
					src_prev_reg <= {ctrl_reg[ch].pos_src, ctrl_reg[ch].neg_src};
					div_reg      <= div_next;
					ref_reg      <= ref_next;
				end
			end

			assign evt_vec[2*ch]   = ev_short;
			assign evt_vec[2*ch+1] = ev_open;
			assign src_pos_en_o[ch]   = ctrl_reg[ch].pos_src;
			assign src_neg_en_o[ch]   = ctrl_reg[ch].neg_src;
			// Registered so the converter mux never sees a decode glitch
			assign test_ref_sel_o[ch] = ref_reg;
			assign test_div_o[ch]     = div_reg;
			assign bipolar_o[ch]      = ctrl_reg[ch].bipolar;

			pos_clamp_a: assert property (
				conv_valid_i[ch] && ctrl_reg[ch].bipolar && ctrl_reg[ch].pos_src && filt_reg[ch]
				|=> res_reg[ch] == 16'h7fff)
				else $error("open positive input did not read positive full scale");
			neg_clamp_a: assert property (
				conv_valid_i[ch] && ctrl_reg[ch].bipolar && !(ctrl_reg[ch].pos_src && filt_reg[ch])
				&& ctrl_reg[ch].neg_src && filt_reg[NUM_CH+ch] |=> res_reg[ch] == 16'h8000)
				else $error("open negative input did not read negative full scale");
			short_flag_a: assert property (
				state_reg == ADCD_CHECK && src_on && conv_valid_i[ch] && forced == base_reg
				&& forced != POS_FS && forced != NEG_FS |=> status_reg[2*ch])
				else $error("unchanged reading did not raise the short flag");
			settle_skip_a: assert property (
				state_reg == ADCD_SETTLE |-> !evt_vec[2*ch] && !evt_vec[2*ch+1])
				else $error("flag raised from an unsettled result");
			test_div_a: assert property (
				ctrl_reg[ch].gain <= 4'h7 || ch == CH_TEMP |=> test_div_o[ch] == 14'h0880)
				else $error("test divider is not 136");
			src_write_a: assert property (
				acc_wr && paddr_i == ((ch == CH_CURR) ? ADDR_CURR_CTRL : ADDR_TEMP_CTRL)
				|=> src_pos_en_o[ch] == $past(pwdata_i[14]) && src_neg_en_o[ch] == $past(pwdata_i[13]))
				else $error("source enable did not follow the control write");
			open_seen_c: cover property (state_reg == ADCD_CHECK ##1 status_reg[2*ch+1]);
			short_seen_c: cover property (state_reg == ADCD_CHECK ##1 status_reg[2*ch]);
		end
	endgenerate

	high_gain_div_a: assert property (
		ctrl_reg[CH_CURR].gain == 4'h8 |=> test_div_o[CH_CURR] == 14'h1100)
		else $error("current test divider wrong at gain 256");
	irq_level_a: assert property (
		irq_o == |(status_reg & mask_reg))
		else $error("interrupt level does not follow masked status");
	sticky_a: assert property (
		status_reg[0] && !(acc_wr && paddr_i == ADDR_STATUS && pwdata_i[0]) |=> status_reg[0])
		else $error("status bit dropped without a clear");
	pready_a: assert property (
		psel_i && penable_i && !pready_reg |=> pready_o ##1 !pready_o)
		else $error("bus answer not one cycle after access");
	irq_raise_c: cover property (!irq_o ##1 irq_o);
endmodule

// [adcd_pkg.sv]
package adcd_pkg;
	localparam int          NUM_CH          = 2;
	localparam int          CH_CURR         = 0;
	localparam int          CH_TEMP         = 1;
	// Register byte offsets
	localparam logic [11:0] ADDR_CURR_CTRL  = 12'h000;
	localparam logic [11:0] ADDR_TEMP_CTRL  = 12'h004;
	localparam logic [11:0] ADDR_CURR_RES   = 12'h008;
	localparam logic [11:0] ADDR_TEMP_RES   = 12'h00c;
	localparam logic [11:0] ADDR_STATUS     = 12'h010;
	localparam logic [11:0] ADDR_MASK       = 12'h014;
	// Control register fields
	localparam int          SRC_POS_BIT     = 14;
	localparam int          SRC_NEG_BIT     = 13;
	localparam int          TSEL_HI         = 7;
	localparam int          TSEL_LO         = 6;
	localparam int          BIPOLAR_BIT     = 5;
	localparam int          GAIN_HI         = 3;
	localparam int          GAIN_LO         = 0;
	localparam logic [1:0]  TSEL_REF        = 2'h2;
	localparam logic        BIPOLAR_RST     = 1'b1;
	// Test divider in sixteenths: 136 fixed, or 1.0625 * gain = 17/16 * gain
	localparam logic [13:0] DIV_FIXED       = 14'h0880;
	localparam logic [13:0] DIV_GAIN_MUL    = 14'h0011;
	localparam logic [3:0]  GAIN_FIXED_MAX  = 4'h7;
	localparam logic [3:0]  GAIN_CODE_MAX   = 4'h9;
	// Full-scale clamp codes
	localparam logic [15:0] POS_FS          = 16'h7fff;
	localparam logic [15:0] NEG_FS          = 16'h8000;
	localparam logic [15:0] RES_RST         = 16'h0000;
	// Status and mask layout: bit 2*ch short, bit 2*ch+1 open
	localparam int          ST_W            = 4;
	localparam logic [3:0]  ST_RST          = 4'h0;
	localparam logic [3:0]  MASK_RST        = 4'h0;

	typedef struct packed {
		logic       pos_src;
		logic       neg_src;
		logic [1:0] test_sel;
		logic       bipolar;
		logic [3:0] gain;
	} adcd_ctrl_s;

	localparam adcd_ctrl_s CTRL_RST = '{pos_src: 1'b0, neg_src: 1'b0, test_sel: 2'h0,
		bipolar: BIPOLAR_RST, gain: 4'h0};

	typedef enum logic [1:0] {
		ADCD_IDLE   = 2'b00,
		ADCD_SETTLE = 2'b01,
		ADCD_CHECK  = 2'b10
	} adcd_state_e;
endpackage

// [adcd_wiring_model.sv]
`timescale 1ns/100ps
module adcd_wiring_model
	import adcd_pkg::*;
(
	input  wire logic                    core_clk_i,
	input  wire logic [NUM_CH-1:0]       src_pos_en_i,
	input  wire logic [NUM_CH-1:0]       src_neg_en_i,
	input  wire logic [NUM_CH-1:0][1:0]  fault_i,
	output logic      [NUM_CH-1:0][15:0] conv_raw_o,
	output logic      [NUM_CH-1:0]       conv_valid_o,
	output logic      [NUM_CH-1:0]       open_hi_o,
	output logic      [NUM_CH-1:0]       open_lo_o
);
	// Fault codes: 0 healthy wiring, 1 short, 2 open
	logic [2:0]  tick_reg = 3'h0;
	logic [15:0] level;

	always_ff @(posedge core_clk_i) begin
		tick_reg <= tick_reg + 3'h1;
	end

	always_comb begin
		level = 16'h0000;
		for (int c = 0; c < NUM_CH; c++) begin
			conv_valid_o[c] = (tick_reg == 3'(c * 4));
			level = 16'h1200 + 16'(c);
			// Test current moves a healthy reading; a short shunts it away
			if ((src_pos_en_i[c] | src_neg_en_i[c]) && fault_i[c] != 2'h1) begin
				level = 16'h1300 + 16'(c);
			end
			// Outside the valid pulse the result lines carry no held value
			conv_raw_o[c] = conv_valid_o[c] ? level : ~level;
			// A floating input is only seen with its own source on
			open_hi_o[c] = (fault_i[c] == 2'h2) & src_pos_en_i[c];
			open_lo_o[c] = (fault_i[c] == 2'h2) & src_neg_en_i[c];
		end
	end
endmodule

// [test_adcd_diag.sv]
`timescale 1ns/100ps
module test_adcd_diag import adcd_pkg::*;;
	logic                    clk;
	logic                    rstn;
	logic [11:0]             paddr;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [31:0]             pwdata;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	logic [NUM_CH-1:0][15:0] conv_raw;
	logic [NUM_CH-1:0]       conv_valid;
	logic [NUM_CH-1:0]       open_hi;
	logic [NUM_CH-1:0]       open_lo;
	logic [NUM_CH-1:0]       src_pos;
	logic [NUM_CH-1:0]       src_neg;
	logic [NUM_CH-1:0]       ref_sel;
	logic [NUM_CH-1:0][13:0] test_div;
	logic [NUM_CH-1:0]       bipolar;
	logic                    irq;
	logic [NUM_CH-1:0][1:0]  fault;
	logic [3:0]              mask_v;
	logic [31:0]             rdata;
	logic [13:0]             exp_div;
	logic                    err;
	int                      mismatches;
	int                      n_tests;

	adcd_diag adcd_diag_inst (.core_clk_i(clk), .rstn_i(rstn), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .conv_raw_i(conv_raw), .conv_valid_i(conv_valid), .open_hi_i(open_hi),
		.open_lo_i(open_lo), .src_pos_en_o(src_pos), .src_neg_en_o(src_neg), .test_ref_sel_o(ref_sel),
		.test_div_o(test_div), .bipolar_o(bipolar), .irq_o(irq));

	adcd_wiring_model adcd_wiring_model_inst (.core_clk_i(clk), .src_pos_en_i(src_pos),
		.src_neg_en_i(src_neg), .fault_i(fault), .conv_raw_o(conv_raw), .conv_valid_o(conv_valid),
		.open_hi_o(open_hi), .open_lo_o(open_lo));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request is held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= addr;
		pwrite <= wr;
		pwdata <= data;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
	endtask

	task rd(input logic [11:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(rdata, exp);
	endtask

	// Baseline with sources off, one source on, a settled fresh result, then compare
	task diag(input int ch, input logic [1:0] f, input logic [31:0] src, input logic [15:0] res,
		input logic [3:0] st);
		logic [11:0] a;
		a = (ch == 1) ? ADDR_TEMP_CTRL : ADDR_CURR_CTRL;
		fault[ch] <= f;
		wr(a, 32'h20);
		repeat (20) @(posedge clk);
		wr(a, 32'h20 | src);
		repeat (30) @(posedge clk);
		rd((ch == 1) ? ADDR_TEMP_RES : ADDR_CURR_RES, {16'h0, res});
		rd(ADDR_STATUS, {28'h0, st});
		@(negedge clk);
		chk({31'h0, irq}, {31'h0, |(st & mask_v)});
		wr(a, 32'h20);
		wr(ADDR_STATUS, 32'hf);
		rd(ADDR_STATUS, 32'h0);
		$display("test diag ch %0d fault %0d src %h done", ch, f, src);
	endtask

	initial begin
		#100000;
		mismatches++;
		print_verdict;
	end

	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		fault = '0;
		mismatches = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(ADDR_CURR_CTRL, 32'h20);
		rd(ADDR_TEMP_CTRL, 32'h20);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_MASK, 32'h0);
		@(negedge clk);
		chk({4'h0, test_div}, {4'h0, 14'h0880, 14'h0880});
		chk({24'h0, bipolar, src_pos, src_neg, ref_sel}, 32'h0000_00c0);
		apb(1'b0, 12'h018, 32'h0);
		chk(rdata, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test reset and map done");
		for (int ch = 0; ch < NUM_CH; ch++) begin
			for (int g = 0; g <= 10; g++) begin
				wr(ch ? ADDR_TEMP_CTRL : ADDR_CURR_CTRL, 32'h6080 | g);
				// Divider and test select are registered once more after the control word lands
				repeat (2) @(negedge clk);
				chk({28'h0, src_pos[ch], src_neg[ch], ref_sel[ch], bipolar[ch]}, 32'he);
				exp_div = (ch == 0 && g > 7) ? 14'(17 << ((g > 9) ? 9 : g)) : DIV_FIXED;
				chk({18'h0, test_div[ch]}, {18'h0, exp_div});
				rd(ch ? ADDR_TEMP_CTRL : ADDR_CURR_CTRL, 32'h6080 | g);
			end
			wr(ch ? ADDR_TEMP_CTRL : ADDR_CURR_CTRL, 32'h0040);
			repeat (2) @(negedge clk);
			chk({29'h0, src_pos[ch], src_neg[ch], ref_sel[ch]}, 32'h0);
		end
		wr(ADDR_STATUS, 32'hf);
		$display("test control fields done");
		mask_v = 4'hf;
		wr(ADDR_MASK, 32'hf);
		for (int ch = 0; ch < NUM_CH; ch++) begin
			diag(ch, 2'h0, 32'h4000, 16'h1300 + 16'(ch), 4'h0);
			diag(ch, 2'h1, 32'h4000, 16'h1200 + 16'(ch), 4'(1 << (2 * ch)));
			diag(ch, 2'h1, 32'h2000, 16'h1200 + 16'(ch), 4'(1 << (2 * ch)));
			diag(ch, 2'h2, 32'h4000, POS_FS, 4'(2 << (2 * ch)));
			diag(ch, 2'h2, 32'h2000, NEG_FS, 4'(2 << (2 * ch)));
		end
		// Masked event still latches status but must not raise the interrupt
		mask_v = 4'h0;
		wr(ADDR_MASK, 32'h0);
		diag(0, 2'h1, 32'h4000, 16'h1200, 4'h1);
		print_verdict;
	end
endmodule
